/* File: verilog/cpp_regs.svh */
// Constants for the crosspoint programming port: APB map, fields, codes.
// Assumes a 32-bit APB slave with word-aligned registers.
`ifndef CPP_REGS_SVH
`define CPP_REGS_SVH

// ==========================================
// Register map
`define CPP_ADDR_W 12
`define CPP_CTRL_ADDR 12'h000
`define CPP_STATUS_ADDR 12'h004
`define CPP_MASTER_ADDR 12'h008
`define CPP_SLAVE_ADDR 12'h00c

// ==========================================
// Fields
`define CPP_CTRL_LATCH_BIT 0
`define CPP_STAT_SERIAL_BIT 0
`define CPP_STAT_EDGE_BIT 1
`define CPP_STAT_OUTEN_BIT 2
`define CPP_STAT_CODE_LSB 4

// ==========================================
// Routing table shape and reset values
`define CPP_OUTPUTS 8
`define CPP_ENTRY_W 4
`define CPP_TABLE_W 32
`define CPP_STAT_W 7
`define CPP_ROUTE_MAX 4'h8
`define CPP_TABLE_RESET 32'h0000_0000
`define CPP_OUTEN_RESET 1'b1

`endif

/* File: verilog/cpp_pkg.sv */
// Types for the crosspoint programming port.
// Assumes cpp_regs.svh for numeric constants other than the command codes.
package cpp_pkg;

	// ==========================================
	// Immediate and latch commands on the parallel code
	typedef enum logic [3:0] {
		CPP_CMD_ALL_OFF = 4'hb,
		CPP_CMD_ALL_ON = 4'hc,
		CPP_CMD_CLR_MASTER = 4'hd,
		CPP_CMD_CLR_ALL = 4'he,
		CPP_CMD_SW_LATCH = 4'hf
	} cpp_cmd_t;

	// ==========================================
	// Pin inputs as one vector for synchronising
	typedef struct packed {
		logic writeStrobe;
		logic chipSelectLow;
		logic chipSelectHigh;
		logic latchInput;
		logic interfaceSelectStrap;
		logic edgeLevelStrap;
		logic [2:0] outputSelect;
		logic [3:0] parallelCode;
	} cpp_pins_t;

endpackage : cpp_pkg

/* File: verilog/cpp_cdc_if.sv */
// Word path from the link domain to the register domain.
// Assumes one feeder and one crossing module.
`timescale 1ns/1ps
interface cpp_cdc_if #(
	parameter int W = 8
) ();
	logic [W-1:0] srcWord;
	logic [W-1:0] dstWord;
	logic dstUpdate;

	modport feeder(output srcWord, input dstWord, input dstUpdate);
	modport crosser(input srcWord, output dstWord, output dstUpdate);
endinterface : cpp_cdc_if

/* File: verilog/cpp_word_sync.sv */
// Toggle handshake that carries a whole word between two clock domains.
// Assumes each domain has its own synchronous reset.
`timescale 1ns/1ps
module cpp_word_sync #(
	parameter int W = 8
) (
	// Source domain
	input wire logic srcClk,
	input wire logic srcReset,
	// Destination domain
	input wire logic dstClk,
	input wire logic dstReset,
	// Word path
	cpp_cdc_if.crosser cdc
);
	logic [W-1:0] heldWord;
	logic reqToggle;
	logic ackMeta;
	logic ackSync;
	logic reqMeta;
	logic reqSync;
	logic reqSeen;

	// ==========================================
	// Source side: resend whenever the last word was taken
	always_ff @(posedge srcClk) begin
		ackMeta <= reqSeen;
		ackSync <= ackMeta;
	end

	always_ff @(posedge srcClk) begin
		if (srcReset) begin
			heldWord <= '0;
			reqToggle <= 1'b0;
		end else if (ackSync == reqToggle) begin
			heldWord <= cdc.srcWord;
			reqToggle <= ~reqToggle;
		end
	end

	// ==========================================
	// Destination side: capture while heldWord is frozen
	always_ff @(posedge dstClk) begin
		reqMeta <= reqToggle;
		reqSync <= reqMeta;
	end

	always_ff @(posedge dstClk) begin
		if (dstReset) begin
			reqSeen <= 1'b0;
			cdc.dstWord <= '0;
			cdc.dstUpdate <= 1'b0;
		end else begin
			cdc.dstUpdate <= reqSync != reqSeen;
			if (reqSync != reqSeen) begin
				reqSeen <= reqSync;
				cdc.dstWord <= heldWord;
			end
		end
	end

endmodule : cpp_word_sync

/* File: verilog/cpp_program_port.sv */
// Programming port of an 8x8 crosspoint: pin-side master/slave routing
// registers on the link clock, APB view of them on ref_clk.
// Assumes pins change slowly against linkClk and both clocks run in reset.
`timescale 1ns/1ps
`include "cpp_regs.svh"
module cpp_program_port (
	// Register clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`CPP_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Link clock
	input wire logic linkClk,
	// Programming pins
	input wire logic writeStrobe,
	input wire logic chipSelectLow,
	input wire logic chipSelectHigh,
	input wire logic latchInput,
	input wire logic interfaceSelectStrap,
	input wire logic edgeLevelStrap,
	input wire logic [2:0] outputSelect,
	input wire logic [3:0] parallelCode,
	// Shared data bit 1 / shift output drive
	output logic shiftOutput,
	output logic shiftOutputEnable_n,
	// Switch decoder side
	output logic [`CPP_TABLE_W-1:0] switchState,
	output logic outputsEnabled
);
	localparam int STAT_XW = `CPP_STAT_W + 2 * `CPP_TABLE_W;

	// ==========================================
	// Code decoding
	// codes 9 and 10 match nothing
	function automatic logic isRoute(input logic [3:0] code);
		isRoute = code <= `CPP_ROUTE_MAX;
	endfunction : isRoute

	function automatic logic isCmd(input logic [3:0] code, input cpp_pkg::cpp_cmd_t cmd);
		isCmd = code == 4'(cmd);
	endfunction : isCmd

	// ==========================================
	// Link domain reset and pin synchronisers
	logic linkResetMeta;
	logic linkReset;
	cpp_pkg::cpp_pins_t pinRaw;
	cpp_pkg::cpp_pins_t pinMeta;
	cpp_pkg::cpp_pins_t pinSync;
	logic strobePrev;
	logic latchPrev;
	logic latchReqMeta;
	logic latchReqSync;
	logic latchReqPrev;

	assign pinRaw = '{writeStrobe: writeStrobe, chipSelectLow: chipSelectLow,
		chipSelectHigh: chipSelectHigh, latchInput: latchInput,
		interfaceSelectStrap: interfaceSelectStrap, edgeLevelStrap: edgeLevelStrap,
		outputSelect: outputSelect, parallelCode: parallelCode};

	always_ff @(posedge linkClk) begin
		linkResetMeta <= reset;
		linkReset <= linkResetMeta;
	end

	always_ff @(posedge linkClk) begin
		pinMeta <= pinRaw;
		pinSync <= pinMeta;
	end

	always_ff @(posedge linkClk) begin
		if (linkReset) begin
			strobePrev <= 1'b0;
			latchPrev <= 1'b0;
			latchReqPrev <= 1'b0;
		end else begin
			strobePrev <= pinSync.writeStrobe;
			latchPrev <= pinSync.latchInput;
			latchReqPrev <= latchReqSync;
		end
	end

	// ==========================================
	// Link domain decode
	logic serialMode;
	logic edgeMode;
	logic strobeRise;
	logic latchRise;
	logic apbLatchPulse;
	logic [3:0] code;
	logic parWrite;
	logic [`CPP_TABLE_W-1:0] master;
	logic [3:0] lastCode;

	assign serialMode = pinSync.interfaceSelectStrap;
	assign edgeMode = pinSync.edgeLevelStrap;
	assign strobeRise = pinSync.writeStrobe & ~strobePrev & ~pinSync.chipSelectLow
		& pinSync.chipSelectHigh;
	assign latchRise = pinSync.latchInput & ~latchPrev;
	assign apbLatchPulse = latchReqSync ^ latchReqPrev;
	assign code = pinSync.parallelCode;
	assign parWrite = strobeRise & ~serialMode;

	// ==========================================
	// Master register
	always_ff @(posedge linkClk) begin
		if (linkReset) begin
			master <= `CPP_TABLE_RESET;
		end else if (strobeRise && serialMode) begin
			// data bit 0 is shift input
			master <= {master[`CPP_TABLE_W-2:0], code[0]};
		end else if (parWrite && isRoute(code)) begin
			master[pinSync.outputSelect*`CPP_ENTRY_W +: `CPP_ENTRY_W] <= code;
		end else if (parWrite && (isCmd(code, cpp_pkg::CPP_CMD_CLR_MASTER)
			|| isCmd(code, cpp_pkg::CPP_CMD_CLR_ALL))) begin
			master <= `CPP_TABLE_RESET;
		end
	end

	// ==========================================
	// Slave register, drives the switch decoders
	always_ff @(posedge linkClk) begin
		if (linkReset) begin
			switchState <= `CPP_TABLE_RESET;
		end else if (parWrite && isCmd(code, cpp_pkg::CPP_CMD_CLR_ALL)) begin
			switchState <= `CPP_TABLE_RESET;
		end else if ((parWrite && isCmd(code, cpp_pkg::CPP_CMD_SW_LATCH)) || apbLatchPulse) begin
			switchState <= master;
		end else if (edgeMode) begin
			if (latchRise) begin
				switchState <= master;
			end
		end else if (!pinSync.latchInput) begin
			switchState <= master;
		end
	end

	// ==========================================
	// Output enable commands and code history
	always_ff @(posedge linkClk) begin
		if (linkReset) begin
			outputsEnabled <= `CPP_OUTEN_RESET;
		end else if (parWrite && isCmd(code, cpp_pkg::CPP_CMD_ALL_OFF)) begin
			outputsEnabled <= 1'b0;
		end else if (parWrite && isCmd(code, cpp_pkg::CPP_CMD_ALL_ON)) begin
			outputsEnabled <= 1'b1;
		end
	end

	always_ff @(posedge linkClk) begin
		if (linkReset) begin
			lastCode <= 4'h0;
		end else if (parWrite) begin
			lastCode <= code;
		end
	end

	// ==========================================
	// Shift output drive on shared data bit 1
	always_ff @(posedge linkClk) begin
		if (linkReset) begin
			shiftOutput <= 1'b0;
			shiftOutputEnable_n <= 1'b1;
		end else begin
			// bit 1 driven only in serial mode
			shiftOutput <= serialMode & master[`CPP_TABLE_W-1];
			shiftOutputEnable_n <= ~serialMode;
		end
	end

	// ==========================================
	// Crossing of tables and status to ref_clk
	cpp_cdc_if #(.W(STAT_XW)) statusLink ();

	assign statusLink.srcWord = {lastCode, outputsEnabled, edgeMode, serialMode,
		switchState, master};

	cpp_word_sync #(.W(STAT_XW)) statusSync (
		.srcClk(linkClk),
		.srcReset(linkReset),
		.dstClk(ref_clk),
		.dstReset(reset),
		.cdc(statusLink.crosser)
	);

	// ==========================================
	// APB slave
	logic latchReqToggle;
	logic apbTake;
	logic [31:0] next_prdata;
	logic next_pslverr;
	logic [`CPP_TABLE_W-1:0] sysMaster;
	logic [`CPP_TABLE_W-1:0] sysSlave;
	logic [`CPP_STAT_W-1:0] sysStat;

	assign {sysStat, sysSlave, sysMaster} = statusLink.dstWord;
	assign apbTake = psel & penable & pready;

	always_comb begin
		next_prdata = 32'h0000_0000;
		next_pslverr = 1'b0;
		unique case (paddr)
			`CPP_CTRL_ADDR: next_prdata = 32'h0000_0000;
			`CPP_STATUS_ADDR: next_prdata = {24'h0, sysStat[6:3], 1'b0, sysStat[2:0]};
			`CPP_MASTER_ADDR: next_prdata = sysMaster;
			`CPP_SLAVE_ADDR: next_prdata = sysSlave;
			default: next_pslverr = 1'b1;
		endcase
		if (pwrite) begin
			next_prdata = 32'h0000_0000;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready <= psel & penable & ~pready;
			if (psel && penable && !pready) begin
				prdata <= next_prdata;
				pslverr <= next_pslverr;
			end else begin
				prdata <= 32'h0000_0000;
				pslverr <= 1'b0;
			end
		end
	end

	// Software latch request, carried as a toggle to the link domain
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			latchReqToggle <= 1'b0;
		end else if (apbTake && pwrite && paddr == `CPP_CTRL_ADDR
			&& pwdata[`CPP_CTRL_LATCH_BIT]) begin
			latchReqToggle <= ~latchReqToggle;
		end
	end

	always_ff @(posedge linkClk) begin
		latchReqMeta <= latchReqToggle;
		latchReqSync <= latchReqMeta;
	end

	// ==========================================
	// Checks on the link domain
	strobe_gate_a: assert property (@(posedge linkClk) disable iff (linkReset)
		!strobeRise |=> $stable(master) && $stable(outputsEnabled))
		else $error("master changed without an enabled strobe");

	serial_shift_a: assert property (@(posedge linkClk) disable iff (linkReset)
		strobeRise && serialMode |=> master == {$past(master[30:0]), $past(code[0])})
		else $error("serial shift wrong");

	route_load_a: assert property (@(posedge linkClk) disable iff (linkReset)
		parWrite && isRoute(code) |=>
		master[4*$past(pinSync.outputSelect) +: 4] == $past(code))
		else $error("parallel entry not loaded");

	cmd_off_a: assert property (@(posedge linkClk) disable iff (linkReset)
		parWrite && code == 4'hb |=> !outputsEnabled ##1 !outputsEnabled || strobeRise)
		else $error("outputs-off command not applied");

	sw_latch_a: assert property (@(posedge linkClk) disable iff (linkReset)
		parWrite && code == 4'hf |=> switchState == $past(master))
		else $error("software latch did not copy");

	edge_copy_a: assert property (@(posedge linkClk) disable iff (linkReset)
		edgeMode && latchRise && !strobeRise |=> switchState == $past(master))
		else $error("latch edge did not copy");

	level_hold_a: assert property (@(posedge linkClk) disable iff (linkReset)
		!edgeMode && pinSync.latchInput && !strobeRise && !apbLatchPulse
		|=> $stable(switchState))
		else $error("slave moved while latch high");

	level_follow_a: assert property (@(posedge linkClk) disable iff (linkReset)
		!edgeMode && !pinSync.latchInput && strobeRise && isRoute(code) && !serialMode
		|=> ##1 switchState == $past(master))
		else $error("transparent slave did not follow");

	shift_out_a: assert property (@(posedge linkClk) disable iff (linkReset)
		serialMode |=> shiftOutput == $past(master[31]) && !shiftOutputEnable_n)
		else $error("shift output not the MSB");

	undefined_a: assert property (@(posedge linkClk) disable iff (linkReset)
		parWrite && (code == 4'h9 || code == 4'ha)
		|=> $stable(master) && $stable(outputsEnabled))
		else $error("undefined code changed state");

endmodule : cpp_program_port

/* File: verification/cpp_host_model.sv */
// Host model: drives the programming pins on the link clock.
// Assumes the testbench calls its tasks one at a time.
`timescale 1ns/1ps
module cpp_host_model (
	// Link clock
	input wire logic linkClk,
	// Programming pins
	output logic writeStrobe,
	output logic chipSelectLow,
	output logic chipSelectHigh,
	output logic latchInput,
	output logic interfaceSelectStrap,
	output logic edgeLevelStrap,
	output logic [2:0] outputSelect,
	output logic [3:0] parallelCode
);
	initial begin
		writeStrobe = 1'b0;
		chipSelectLow = 1'b1;
		chipSelectHigh = 1'b0;
		latchInput = 1'b0;
		interfaceSelectStrap = 1'b0;
		edgeLevelStrap = 1'b0;
		outputSelect = 3'h0;
		parallelCode = 4'h0;
	end

	// ==========================================
	// Straps and latch, then time to settle
	task automatic set_mode(input logic ser, input logic edg, input logic lat);
		@(posedge linkClk);
		interfaceSelectStrap <= ser;
		edgeLevelStrap <= edg;
		latchInput <= lat;
		repeat (10) @(posedge linkClk);
	endtask : set_mode

	// ==========================================
	// One strobe with setup and hold of three cycles
	task automatic put(input logic [3:0] code, input logic [2:0] sel, input logic en);
		@(posedge linkClk);
		parallelCode <= code;
		outputSelect <= sel;
		chipSelectLow <= ~en;
		chipSelectHigh <= en;
		repeat (3) @(posedge linkClk);
		writeStrobe <= 1'b1;
		repeat (3) @(posedge linkClk);
		writeStrobe <= 1'b0;
		repeat (3) @(posedge linkClk);
		// Released lines show the inverse, not stale data
		parallelCode <= ~code;
		outputSelect <= ~sel;
		chipSelectLow <= 1'b1;
		chipSelectHigh <= 1'b0;
	endtask : put
endmodule : cpp_host_model

/* File: verification/cpp_program_port_tb.sv */
// Testbench: pins through the host model, results read back over APB.
// Assumes cpp_regs.svh and a free-running link clock.
`timescale 1ns/1ps
`include "cpp_regs.svh"
module cpp_program_port_tb;
	logic ref_clk, reset, linkClk, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, switchState, m, s;
	logic writeStrobe, chipSelectLow, chipSelectHigh, latchInput, serStrap, edgeStrap;
	logic [2:0] outputSelect;
	logic [3:0] parallelCode, c;
	logic shiftOutput, shiftOutputEnable_n, outputsEnabled;
	logic [32:0] expQ[$];
	int numErrors, nChecks, seed;

	cpp_program_port u_cpp_program_port (.ref_clk(ref_clk), .reset(reset), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .linkClk(linkClk), .writeStrobe(writeStrobe),
		.chipSelectLow(chipSelectLow), .chipSelectHigh(chipSelectHigh),
		.latchInput(latchInput), .interfaceSelectStrap(serStrap), .edgeLevelStrap(edgeStrap),
		.outputSelect(outputSelect), .parallelCode(parallelCode), .shiftOutput(shiftOutput),
		.shiftOutputEnable_n(shiftOutputEnable_n), .switchState(switchState),
		.outputsEnabled(outputsEnabled));
	cpp_host_model u_cpp_host_model (.linkClk(linkClk), .writeStrobe(writeStrobe),
		.chipSelectLow(chipSelectLow), .chipSelectHigh(chipSelectHigh),
		.latchInput(latchInput), .interfaceSelectStrap(serStrap), .edgeLevelStrap(edgeStrap),
		.outputSelect(outputSelect), .parallelCode(parallelCode));

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	initial begin
		linkClk = 1'b0;
		#1.7;
		forever #3 linkClk = ~linkClk;
	end

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		nChecks++;
		if (seen !== exp) begin
			numErrors++;
			$display("unexpected %s: expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic end_of_test;
		$display("checks %0d errors %0d", nChecks, numErrors);
		if (numErrors == 0 && nChecks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_of_test

	// ==========================================
	// APB transfer; reads note the expected answer
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
		input logic err);
		int n;
		repeat (20) @(posedge ref_clk);
		if (!wr) expQ.push_back({err, d});
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50) begin
			numErrors++;
			end_of_test();
		end
	endtask : apb

	// ==========================================
	// Monitor: compares each read answer with the oldest note
	always @(posedge ref_clk) begin
		if (psel && penable && pready === 1'b1 && !pwrite && expQ.size() > 0) begin
			check("pslverr", {31'h0, pslverr}, {31'h0, expQ[0][32]});
			if (!expQ[0][32]) check("prdata", prdata, expQ[0][31:0]);
			void'(expQ.pop_front());
		end
	end

	initial begin
		seed = 63707;
		numErrors = 0;
		nChecks = 0;
		reset = 1'b1;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		repeat (20) @(posedge ref_clk);
		reset <= 1'b0;
		m = '0;
		s = '0;
		apb(1'b0, `CPP_SLAVE_ADDR, s, 1'b0);
		apb(1'b0, 12'h010, 32'h0, 1'b1);
		u_cpp_host_model.set_mode(1'b0, 1'b0, 1'b0);
		for (int k = 0; k < 8; k++) begin
			c = 4'($unsigned($random(seed)) % 9);
			m[4*k+:4] = c;
			u_cpp_host_model.put(c, 3'(k), 1'b1);
		end
		s = m;
		apb(1'b0, `CPP_MASTER_ADDR, m, 1'b0);
		apb(1'b0, `CPP_SLAVE_ADDR, s, 1'b0);
		u_cpp_host_model.put(4'h3, 3'h0, 1'b0);
		u_cpp_host_model.put(4'h9, 3'h1, 1'b1);
		u_cpp_host_model.put(4'ha, 3'h2, 1'b1);
		apb(1'b0, `CPP_MASTER_ADDR, m, 1'b0);
		apb(1'b0, `CPP_SLAVE_ADDR, s, 1'b0);
		check("shiftOutputEnable_n", {31'h0, shiftOutputEnable_n}, 32'h1);
		u_cpp_host_model.set_mode(1'b0, 1'b0, 1'b1);
		u_cpp_host_model.put(4'h5, 3'h2, 1'b1);
		m[11:8] = 4'h5;
		apb(1'b0, `CPP_SLAVE_ADDR, s, 1'b0);
		u_cpp_host_model.put(4'hf, 3'h0, 1'b1);
		s = m;
		apb(1'b0, `CPP_SLAVE_ADDR, s, 1'b0);
		u_cpp_host_model.set_mode(1'b0, 1'b1, 1'b0);
		u_cpp_host_model.put(4'h7, 3'h1, 1'b1);
		m[7:4] = 4'h7;
		apb(1'b0, `CPP_SLAVE_ADDR, s, 1'b0);
		u_cpp_host_model.set_mode(1'b0, 1'b1, 1'b1);
		s = m;
		apb(1'b0, `CPP_SLAVE_ADDR, s, 1'b0);
		u_cpp_host_model.put(4'hd, 3'h0, 1'b1);
		m = '0;
		apb(1'b0, `CPP_MASTER_ADDR, m, 1'b0);
		apb(1'b0, `CPP_SLAVE_ADDR, s, 1'b0);
		u_cpp_host_model.put(4'hb, 3'h0, 1'b1);
		apb(1'b0, `CPP_STATUS_ADDR, 32'hb2, 1'b0);
		check("outputsEnabled", {31'h0, outputsEnabled}, 32'h0);
		u_cpp_host_model.put(4'hc, 3'h0, 1'b1);
		apb(1'b0, `CPP_STATUS_ADDR, 32'hc6, 1'b0);
		u_cpp_host_model.put(4'h2, 3'h7, 1'b1);
		m = 32'h2000_0000;
		apb(1'b1, `CPP_CTRL_ADDR, 32'h1, 1'b0);
		s = m;
		apb(1'b0, `CPP_SLAVE_ADDR, s, 1'b0);
		u_cpp_host_model.put(4'he, 3'h0, 1'b1);
		apb(1'b0, `CPP_SLAVE_ADDR, 32'h0, 1'b0);
		check("switchState", switchState, 32'h0);
		u_cpp_host_model.set_mode(1'b1, 1'b0, 1'b1);
		m = '0;
		for (int k = 0; k < 32; k++) begin
			c = 4'($random(seed));
			m = {m[30:0], c[0]};
			u_cpp_host_model.put(c, 3'($random(seed)), 1'b1);
		end
		apb(1'b0, `CPP_MASTER_ADDR, m, 1'b0);
		check("shiftOutput", {31'h0, shiftOutput}, {31'h0, m[31]});
		check("shiftOutputEnable_n", {31'h0, shiftOutputEnable_n}, 32'h0);
		apb(1'b0, `CPP_STATUS_ADDR, 32'he5, 1'b0);
		end_of_test();
	end
endmodule : cpp_program_port_tb
